// ==== logic/cie_pkg.sv ====
// Purpose: shared constants and types of the instruction decode and execute core
// Assumes: one clock, four clocks make one instruction cycle
// Notes: register offsets are 7-bit file addresses
//
// Overview of operation
// RULE1 - fetch and decode one 14-bit instruction word
// RULE2 - d=0 writes working register, d=1 file
// RULE3 - file operand addresses 0x00 through 0x7F
// RULE4 - bit select changes only one register bit
// RULE5 - literal is 8-bit or 11-bit per instruction
// RULE6 - instruction cycle is four oscillator periods
// RULE7 - one cycle; taken test or jump adds NOP
// RULE8 - file instructions always read before writing
// RULE9 - port A read clears change mismatch
// RULE10 - don't-care instruction bits never change operation
// RULE11 - interrupt wake with global enable vectors
// RULE12 - wake sets source bits in interrupt control
// RULE13 - brown-out clears reset-cause bit 0 only
// RULE14 - flags update only for defined instructions
package cie_pkg;
  // =========================================================
  // register map
  localparam logic [6:0] REG_IND_PORT = 7'h00;
  localparam logic [6:0] REG_PC_LOW   = 7'h02;
  localparam logic [6:0] REG_STATUS   = 7'h03;
  localparam logic [6:0] REG_IND_PTR  = 7'h04;
  localparam logic [6:0] REG_PORT_A   = 7'h05;
  localparam logic [6:0] REG_PC_LATCH = 7'h0A;
  localparam logic [6:0] REG_INT_CTL  = 7'h0B;
  localparam logic [6:0] REG_CAUSE   = 7'h1A;
  localparam logic [6:0] GPR_BASE    = 7'h20;
  // =========================================================
  // reset values and fields
  localparam logic [7:0]  STATUS_RST = 8'h18;
  localparam logic [7:0]  PC_LATCH_RST = 8'h00;
  localparam logic [7:0]  INT_CTL_RST  = 8'h00;
  localparam logic [7:0]  CAUSE_RST  = 8'h00;
  localparam logic [12:0] RST_VEC    = 13'h0000;
  localparam logic [12:0] INT_VEC    = 13'h0004;
  localparam int ST_C   = 0;
  localparam int ST_DCY = 1;
  localparam int ST_Z   = 2;
  localparam int ST_PWD = 3;
  localparam int ST_TMO = 4;
  localparam int ST_RP0 = 5;
  localparam int GLB_IE_B = 7;
  localparam int BOR_B  = 0;
  localparam logic [7:0] ST_RO_MASK = 8'h18;
  // =========================================================
  // timing
  localparam int OSC_PER_CYC = 4;
  localparam logic [1:0] Q_READ = 2'h0;
  localparam logic [1:0] Q_LAT  = 2'h1;
  localparam logic [1:0] Q_EXE  = 2'h2;
  localparam logic [1:0] Q_WB   = 2'h3;
  // =========================================================
  // types
  typedef enum logic [3:0] {
    A_PASSA, A_PASSB, A_CLR, A_SUB, A_DEC, A_IOR, A_AND, A_XOR,
    A_ADD, A_COM, A_INC, A_RR, A_RL, A_SWAP, A_BCLR, A_BSET
  } cie_alu_op_t;
  typedef enum logic [1:0] {RS_POR, RS_EXT, RS_WDT, RS_BOR} cie_rst_src_t;
  typedef struct packed {
    logic z;
    logic dcy;
    logic c;
  } cie_flags_t;
  typedef struct packed {
    logic [7:0] addr;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
  } cie_per_req_t;
  typedef struct packed {
    cie_alu_op_t op;
    logic lit, file, wr_w, wr_f, fz, fcdc, fc, tskip, btest, bval;
    logic jmp, call, ret, rlw, rfie, slp, cwdt;
  } cie_ctl_t;
endpackage : cie_pkg

// ==== logic/cie_ram.sv ====
// Purpose: general purpose file registers
// Assumes: read data valid one clock after the address
// Notes: banks share one array
`timescale 1ns/1ps
`default_nettype none
module cie_ram (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic [6:0] addr,
  input  wire logic       we,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata
);
  logic [7:0] mem [0:127];
  // =========================================================
  // storage with registered read
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem[addr];
    end
  end
endmodule // cie_ram
`default_nettype wire

// ==== logic/cie_alu.sv ====
// Purpose: arithmetic and logic unit
// Assumes: a is the working register, b the file value or literal
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module cie_alu (
  input  wire cie_pkg::cie_alu_op_t op,
  input  wire logic [7:0]           a,
  input  wire logic [7:0]           b,
  input  wire logic [2:0]           bsel,
  input  wire logic                 cin,
  output logic      [7:0]           res,
  output cie_pkg::cie_flags_t       fl
);
  import cie_pkg::*;
  logic [8:0] s9;
  logic [4:0] s5;
  logic [7:0] msk;
  // =========================================================
  // operations
  always_comb begin
    s9 = 9'h000;
    s5 = 5'h00;
    msk = 8'h01 << bsel; // RULE4
    res = 8'h00;
    fl.c = cin;
    case (op)
      A_PASSA: res = a;
      A_PASSB: res = b;
      A_CLR:   res = 8'h00;
      A_SUB: begin
        s9 = {1'b0, b} + {1'b0, ~a} + 9'h001;
        s5 = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
        res = s9[7:0];
      end
      A_ADD: begin
        s9 = {1'b0, b} + {1'b0, a};
        s5 = {1'b0, b[3:0]} + {1'b0, a[3:0]};
        res = s9[7:0];
      end
      A_DEC:   res = b - 8'h01;
      A_INC:   res = b + 8'h01;
      A_IOR:   res = a | b;
      A_AND:   res = a & b;
      A_XOR:   res = a ^ b;
      A_COM:   res = ~b;
      A_RR: begin
        res = {cin, b[7:1]};
        fl.c = b[0];
      end
      A_RL: begin
        res = {b[6:0], cin};
        fl.c = b[7];
      end
      A_SWAP:  res = {b[3:0], b[7:4]};
      A_BCLR:  res = b & ~msk; // RULE4
      A_BSET:  res = b | msk; // RULE4
      default: res = b;
    endcase
    if (op == A_SUB || op == A_ADD) begin
      fl.c = s9[8];
    end
    fl.dcy = s5[4];
    fl.z = (res == 8'h00);
  end
endmodule // cie_alu
`default_nettype wire

// ==== logic/cie_core.sv ====
// Purpose: instruction decode and execute control
// Assumes: program data valid in the same clock as prog_addr; peripheral read data valid one clock after rd
// Notes: phase 0 read, 1 latch, 2 execute, 3 write back and fetch
`timescale 1ns/1ps
`default_nettype none
module cie_core (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  input  wire logic                  rst_por_b,
  input  wire cie_pkg::cie_rst_src_t rst_src,
  output logic [12:0]                prog_addr,
  input  wire logic [13:0]           prog_data,
  output cie_pkg::cie_per_req_t      per_req,
  input  wire logic [7:0]            per_rdata,
  output logic                       port_a_rd,
  input  wire logic                  irq_pend,
  input  wire logic                  wake_irq,
  input  wire logic                  wake_wdt,
  input  wire logic [7:0]            wake_set,
  output logic                       wdt_clr,
  output logic                       sleep_mode,
  output logic                       cyc_strobe,
  output logic [7:0]                 status_out,
  output logic [7:0]                 cause_out
);
  import cie_pkg::*;

  typedef struct packed {
    logic [1:0]       qc;
    logic [13:0]      ir;
    logic [12:0]      pc;
    logic [7:0]       w;
    logic [7:0]       status;
    logic [7:0]       iptr;
    logic [7:0]       pc_latch;
    logic [7:0]       int_ctl;
    logic [7:0][12:0] stk;
    logic [2:0]       sp;
    logic [7:0]       fv;
    logic [7:0]       res;
    logic [7:0]       addr;
    logic             wb;
    logic             kill;
    logic             kadv;
    logic             sleep;
    logic             init;
  } cie_st_t;

  cie_st_t    st_q;
  cie_st_t    st_d;
  cie_ctl_t   ctl;
  logic [7:0] ram_rdata;
  logic [7:0] alu_b;
  logic [7:0] alu_res;
  cie_flags_t alu_fl;
  logic [7:0] cause_q;
  logic       ram_we;
  logic       idle;

  // =========================================================
  // decode
  function automatic cie_ctl_t dec(input logic [13:0] i);
    cie_ctl_t c;
    c = '0;
    c.op = A_PASSB;
    case (i[13:12])
      2'b00: begin
        c.file = 1'b1;
        c.wr_f = i[7]; // RULE2
        c.wr_w = ~i[7]; // RULE2
        case (i[11:8])
          4'h0: begin
            c.op = A_PASSA;
            c.file = i[7];
            c.wr_w = 1'b0;
            casez (i[7:0])
              8'b0000_1000: c.ret = 1'b1;
              8'b0000_1001: c.rfie = 1'b1;
              8'b0110_0011: c.slp = 1'b1;
              8'b0110_0100: c.cwdt = 1'b1;
              default: c.ret = 1'b0; // RULE10
            endcase
          end
          4'h1: begin
            c.op = A_CLR;
            c.fz = 1'b1;
            c.file = i[7]; // RULE10
          end
          4'h2: {c.op, c.fz, c.fcdc} = {A_SUB, 2'b11};
          4'h3: {c.op, c.fz} = {A_DEC, 1'b1};
          4'h4: {c.op, c.fz} = {A_IOR, 1'b1};
          4'h5: {c.op, c.fz} = {A_AND, 1'b1};
          4'h6: {c.op, c.fz} = {A_XOR, 1'b1};
          4'h7: {c.op, c.fz, c.fcdc} = {A_ADD, 2'b11};
          4'h8: {c.op, c.fz} = {A_PASSB, 1'b1};
          4'h9: {c.op, c.fz} = {A_COM, 1'b1};
          4'hA: {c.op, c.fz} = {A_INC, 1'b1};
          4'hB: {c.op, c.tskip} = {A_DEC, 1'b1};
          4'hC: {c.op, c.fc} = {A_RR, 1'b1};
          4'hD: {c.op, c.fc} = {A_RL, 1'b1};
          4'hE: c.op = A_SWAP;
          default: {c.op, c.tskip} = {A_INC, 1'b1};
        endcase
      end
      2'b01: begin
        c.file = 1'b1;
        c.op = i[10] ? A_BSET : A_BCLR;
        c.wr_f = ~i[11];
        c.btest = i[11];
        c.bval = i[10];
      end
      2'b10: begin
        c.jmp = 1'b1;
        c.call = ~i[11];
      end
      default: begin
        c.lit = 1'b1;
        c.wr_w = 1'b1;
        casez (i[11:8]) // RULE10
          4'b00??: c.op = A_PASSB;
          4'b01??: {c.rlw, c.wr_w} = 2'b10;
          4'b1000: {c.op, c.fz} = {A_IOR, 1'b1};
          4'b1001: {c.op, c.fz} = {A_AND, 1'b1};
          4'b1010: {c.op, c.fz} = {A_XOR, 1'b1};
          4'b110?: {c.op, c.fz, c.fcdc} = {A_SUB, 2'b11};
          4'b111?: {c.op, c.fz, c.fcdc} = {A_ADD, 2'b11};
          default: c.wr_w = 1'b0;
        endcase
      end
    endcase
    return c;
  endfunction

  // =========================================================
  // address helpers
  function automatic logic [7:0] eff(input logic [6:0] f, input logic [7:0] iptr, input logic rp0);
    return (f == REG_IND_PORT) ? iptr : {rp0, f};
  endfunction

  function automatic logic is_core(input logic [6:0] a);
    return a == REG_IND_PORT || a == REG_PC_LOW || a == REG_STATUS || a == REG_IND_PTR ||
           a == REG_PC_LATCH || a == REG_INT_CTL || a == REG_CAUSE;
  endfunction

  function automatic logic is_per(input logic [6:0] a);
    return (a < GPR_BASE) && !is_core(a);
  endfunction

  // =========================================================
  // datapath instances
  assign ctl = dec(st_q.ir); // RULE1
  assign alu_b = ctl.lit ? st_q.ir[7:0] : st_q.fv; // RULE5
  assign ram_we = st_q.qc == Q_WB && st_q.wb && st_q.addr[6:0] >= GPR_BASE;

  cie_alu u_alu (
    .op   (ctl.op),
    .a    (st_q.w),
    .b    (alu_b),
    .bsel (st_q.ir[9:7]),
    .cin  (st_q.status[ST_C]),
    .res  (alu_res),
    .fl   (alu_fl)
  );

  cie_ram u_ram (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .addr    (st_q.addr[6:0]),
    .we      (ram_we),
    .wdata   (st_q.res),
    .rdata   (ram_rdata)
  );

  // =========================================================
  // sequencing
  always_comb begin
    st_d = st_q;
    st_d.qc = st_q.qc + 2'h1; // RULE6
    if (!st_q.init) begin
      st_d.init = 1'b1;
      if (rst_src == RS_WDT) begin
        st_d.status[ST_TMO] = 1'b0;
      end
    end
    case (st_q.qc)
      Q_READ: begin
        st_d.wb = 1'b0;
      end
      Q_LAT: begin
        // RULE8
        case (st_q.addr[6:0])
          REG_IND_PORT: st_d.fv = 8'h00;
          REG_PC_LOW:   st_d.fv = st_q.pc[7:0];
          REG_STATUS:   st_d.fv = st_q.status;
          REG_IND_PTR:  st_d.fv = st_q.iptr;
          REG_PC_LATCH: st_d.fv = st_q.pc_latch;
          REG_INT_CTL:  st_d.fv = st_q.int_ctl;
          REG_CAUSE:  st_d.fv = cause_q;
          default:    st_d.fv = (st_q.addr[6:0] >= GPR_BASE) ? ram_rdata : per_rdata; // RULE3
        endcase
      end
      Q_EXE: begin
        if (st_q.kill) begin
          st_d.kill = 1'b0; // RULE7
          st_d.pc = st_q.pc + {12'h000, st_q.kadv}; // RULE7
        end else if (st_q.sleep) begin
          if (wake_irq || wake_wdt) begin
            st_d.sleep = 1'b0;
            st_d.int_ctl = st_q.int_ctl | wake_set; // RULE12
            if (wake_wdt) begin
              st_d.status[ST_TMO] = 1'b0;
            end
          end
        end else if (irq_pend && st_q.int_ctl[GLB_IE_B]) begin
          st_d.stk[st_q.sp] = st_q.pc;
          st_d.sp = st_q.sp + 3'h1;
          st_d.pc = INT_VEC; // RULE11
          st_d.int_ctl[GLB_IE_B] = 1'b0;
          st_d.kill = 1'b1;
          st_d.kadv = 1'b0;
        end else begin
          st_d.pc = st_q.pc + 13'h0001;
          st_d.res = alu_res;
          if (ctl.wr_w) begin
            st_d.w = alu_res; // RULE2
          end
          if (ctl.wr_f) begin
            st_d.wb = 1'b1; // RULE2
            case (st_q.addr[6:0])
              REG_PC_LOW: begin
                st_d.pc = {st_q.pc_latch[4:0], alu_res};
                st_d.kill = 1'b1; // RULE7
                st_d.kadv = 1'b0;
              end
              REG_STATUS: st_d.status = (alu_res & ~ST_RO_MASK) | (st_q.status & ST_RO_MASK);
              REG_IND_PTR:  st_d.iptr = alu_res;
              REG_PC_LATCH: st_d.pc_latch = alu_res;
              REG_INT_CTL:  st_d.int_ctl = alu_res;
              default:    st_d.wb = 1'b1;
            endcase
          end
          if (ctl.fz) begin
            st_d.status[ST_Z] = alu_fl.z; // RULE14
          end
          if (ctl.fcdc) begin
            st_d.status[ST_C] = alu_fl.c; // RULE14
            st_d.status[ST_DCY] = alu_fl.dcy; // RULE14
          end
          if (ctl.fc) begin
            st_d.status[ST_C] = alu_fl.c; // RULE14
          end
          if ((ctl.tskip && alu_fl.z) || (ctl.btest && st_q.fv[st_q.ir[9:7]] == ctl.bval)) begin
            st_d.kill = 1'b1; // RULE7
            st_d.kadv = 1'b1;
          end
          if (ctl.jmp) begin
            if (ctl.call) begin
              st_d.stk[st_q.sp] = st_q.pc + 13'h0001;
              st_d.sp = st_q.sp + 3'h1;
            end
            st_d.pc = {st_q.pc_latch[4:3], st_q.ir[10:0]}; // RULE5
            st_d.kill = 1'b1; // RULE7
            st_d.kadv = 1'b0;
          end
          if (ctl.ret || ctl.rlw || ctl.rfie) begin
            st_d.sp = st_q.sp - 3'h1;
            st_d.pc = st_q.stk[st_q.sp - 3'h1];
            st_d.kill = 1'b1; // RULE7
            st_d.kadv = 1'b0;
          end
          if (ctl.rlw) begin
            st_d.w = st_q.ir[7:0];
          end
          if (ctl.rfie) begin
            st_d.int_ctl[GLB_IE_B] = 1'b1;
          end
          if (ctl.slp) begin
            st_d.sleep = 1'b1;
            st_d.status[ST_TMO] = 1'b1;
            st_d.status[ST_PWD] = 1'b0;
          end
          if (ctl.cwdt) begin
            st_d.status[ST_TMO] = 1'b1;
            st_d.status[ST_PWD] = 1'b1;
          end
        end
      end
      default: begin
        st_d.ir = prog_data; // RULE1
        st_d.addr = eff(prog_data[6:0], st_q.iptr, st_q.status[ST_RP0]); // RULE3
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
      st_q.pc <= RST_VEC;
      st_q.status <= STATUS_RST;
      st_q.pc_latch <= PC_LATCH_RST;
      st_q.int_ctl <= INT_CTL_RST;
      st_q.kill <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // =========================================================
  // reset cause, kept across all resets but power-on; brown-out clears bit 0
  always_ff @(posedge clk_sys or negedge rst_por_b) begin
    if (!rst_por_b) begin
      cause_q <= CAUSE_RST;
    end else if (!st_q.init && rst_src == RS_BOR) begin
      cause_q[BOR_B] <= 1'b0; // RULE13
    end else if (st_q.qc == Q_WB && st_q.wb && st_q.addr[6:0] == REG_CAUSE) begin
      cause_q <= st_q.res;
    end
  end

  // =========================================================
  // outputs
  assign idle = st_q.kill || st_q.sleep;
  assign prog_addr = st_q.pc;
  assign per_req.addr = st_q.addr;
  assign per_req.wdata = st_q.res;
  assign per_req.rd = st_q.qc == Q_READ && !idle && ctl.file && is_per(st_q.addr[6:0]); // RULE8
  assign per_req.wr = st_q.qc == Q_WB && st_q.wb && is_per(st_q.addr[6:0]);
  assign port_a_rd = per_req.rd && st_q.addr == {1'b0, REG_PORT_A}; // RULE9
  assign wdt_clr = st_q.qc == Q_EXE && !idle && ctl.cwdt;
  assign sleep_mode = st_q.sleep;
  assign cyc_strobe = st_q.qc == Q_WB;
  assign status_out = st_q.status;
  assign cause_out = cause_q;
endmodule // cie_core
`default_nettype wire

// ==== testbench/cie_mem_model.sv ====
// Purpose: program memory and peripheral register model
// Assumes: fetch is combinational, read data one clock after rd
// Notes: read data that is not refreshed by rd flips every clock
`timescale 1ns/1ps
`default_nettype none
module cie_mem_model (
  input  wire logic                  clk_sys,
  input  wire logic [12:0]           prog_addr,
  output logic      [13:0]           prog_data,
  input  wire cie_pkg::cie_per_req_t per_req,
  output logic      [7:0]            per_rdata
);
  import cie_pkg::*;
  // =========================================================
  // storage
  logic [13:0] rom  [0:31];
  logic [7:0]  regs [0:255];
  initial begin
    per_rdata = 8'h00;
    foreach (regs[i]) regs[i] = 8'h00;
  end
  assign prog_data = rom[prog_addr[4:0]];
  always @(posedge clk_sys) begin
    per_rdata <= per_req.rd ? regs[per_req.addr] : ~per_rdata;
    if (per_req.wr) regs[per_req.addr] <= per_req.wdata;
  end
endmodule // cie_mem_model
`default_nettype wire

// ==== testbench/cie_core_monitor.sv ====
// Purpose: port checker of the decode and execute core
// Assumes: one clock domain, reset active low
// Notes: attached by bind below
`timescale 1ns/1ps
`default_nettype none
module cie_core_monitor
  import cie_pkg::*;
(
  input wire logic                  clk_sys,
  input wire logic                  rst_b,
  input wire cie_pkg::cie_rst_src_t rst_src,
  input wire logic [12:0]           prog_addr,
  input wire cie_pkg::cie_per_req_t per_req,
  input wire logic                  port_a_rd,
  input wire logic                  sleep_mode,
  input wire logic                  cyc_strobe,
  input wire logic [7:0]            cause_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // =========================================================
  // properties
  property p_cyc_period; cyc_strobe |=> !cyc_strobe [*3] ##1 cyc_strobe; endproperty
  property p_rd_phase; per_req.rd |-> !cyc_strobe ##3 cyc_strobe; endproperty
  property p_wr_after_rd; per_req.wr |-> $past(per_req.rd, 3) && ($past(per_req.addr, 3) == per_req.addr); endproperty
  property p_port_read; port_a_rd == (per_req.rd && (per_req.addr == 8'h05)); endproperty
  property p_fetch_hold; !$stable(prog_addr) |-> cyc_strobe; endproperty
  property p_rd_range; per_req.rd |-> (per_req.addr[6:0] < GPR_BASE) && !sleep_mode; endproperty
  property p_bor_clear; $rose(rst_b) && (rst_src == RS_BOR) |-> ##2 !cause_out[BOR_B]; endproperty
  property p_cause_keep; $rose(rst_b) && (rst_src != RS_BOR) |-> ##2 cause_out == $past(cause_out, 2); endproperty
  // =========================================================
  // assertions
  a_cyc_period: assert property (p_cyc_period) else $error("cycle strobe spacing wrong");
  a_rd_phase: assert property (p_rd_phase) else $error("read not in first phase");
  a_wr_after_rd: assert property (p_wr_after_rd) else $error("write without prior read");
  a_port_read: assert property (p_port_read) else $error("port read pulse wrong");
  a_fetch_hold: assert property (p_fetch_hold) else $error("fetch address moved early");
  a_rd_range: assert property (p_rd_range) else $error("read address out of range");
  a_bor_clear: assert property (p_bor_clear) else $error("cause bit 0 not cleared");
  a_cause_keep: assert property (p_cause_keep) else $error("cause changed by reset");
  c_write: cover property (per_req.wr);
  c_port: cover property (port_a_rd);
  c_bor: cover property ($rose(rst_b) && (rst_src == RS_BOR));
endmodule // cie_core_monitor
bind cie_core cie_core_monitor u_mon (.clk_sys(clk_sys), .rst_b(rst_b), .rst_src(rst_src),
  .prog_addr(prog_addr), .per_req(per_req), .port_a_rd(port_a_rd), .sleep_mode(sleep_mode),
  .cyc_strobe(cyc_strobe), .cause_out(cause_out));
`default_nettype wire

// ==== testbench/core_instruction_execute_test.sv ====
// Purpose: self-checking bench of the decode and execute core
// Assumes: program runs from the memory model, results seen on the peripheral bus
// Notes: three runs, for power-on, watchdog and brown-out reset
`timescale 1ns/1ps
`default_nettype none
module core_instruction_execute_test;
  import cie_pkg::*;
  logic         clk_sys   = 1'b0;
  logic         rst_b     = 1'b0;
  logic         rst_por_b = 1'b0;
  cie_rst_src_t rst_src   = RS_POR;
  logic [12:0]  prog_addr;
  logic [13:0]  prog_data;
  cie_per_req_t per_req;
  logic [7:0]   per_rdata, status_out, cause_out;
  logic         port_a_rd, cyc_strobe;
  logic [23:0]  exp_q [$];
  int           fails, n_compared, cyc, n_rd, n_pa;
  always #12.5 clk_sys = ~clk_sys;
  cie_core dut (.clk_sys(clk_sys), .rst_b(rst_b), .rst_por_b(rst_por_b), .rst_src(rst_src),
    .prog_addr(prog_addr), .prog_data(prog_data), .per_req(per_req), .per_rdata(per_rdata),
    .port_a_rd(port_a_rd), .irq_pend(1'b0), .wake_irq(1'b0), .wake_wdt(1'b0), .wake_set(8'h00),
    .wdt_clr(), .sleep_mode(), .cyc_strobe(cyc_strobe), .status_out(status_out), .cause_out(cause_out));
  cie_mem_model mem (.clk_sys(clk_sys), .prog_addr(prog_addr), .prog_data(prog_data),
    .per_req(per_req), .per_rdata(per_rdata));
  // =========================================================
  // checking
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    if (fails == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      cyc = 0;
      n_rd = 0;
      n_pa = 0;
    end else begin
      if (per_req.rd === 1'b1) n_rd++;
      if (port_a_rd === 1'b1) n_pa++;
      if (per_req.wr === 1'b1) check("write", exp_q.pop_front(), {cyc[7:0], per_req.addr, per_req.wdata});
      if (cyc_strobe === 1'b1) cyc++;
    end
  end
  // =========================================================
  // one run: program, reference model, checks
  function automatic logic [13:0] mw(input logic [6:0] f);
    return {7'b0000001, f};
  endfunction
  task automatic run(input cie_rst_src_t src, input logic [7:0] cause_exp);
    logic [7:0] k1, k2, k3, r, to;
    logic [8:0] s;
    logic [2:0] b1, b2, b3;
    logic [1:0] x;
    logic       dcy;
    k1 = 8'($urandom);
    k2 = 8'($urandom);
    k3 = 8'($urandom);
    {b1, b2, b3, x} = 11'($urandom);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    rst_src <= src;
    if (src == RS_POR) rst_por_b <= 1'b0;
    for (int i = 0; i < 32; i++) mem.rom[i] = mw(7'h11);
    mem.rom[0] = {4'b1100, x, k1};
    mem.rom[1] = mw(7'h0C);
    mem.rom[2] = {5'b11111, x[0], k2};
    mem.rom[3] = mw(7'h0D);
    mem.rom[4] = {7'b0000011, 7'h05};
    mem.rom[5] = {4'b0101, b1, 7'h0C};
    mem.rom[6] = {4'b0100, b2, 7'h0C};
    mem.rom[7] = {7'b0010000, 7'h0C};
    mem.rom[8] = mw(7'h0E);
    mem.rom[9] = {7'b0010101, 7'h0E};
    mem.rom[10] = {4'b0110, b3, 7'h0C};
    mem.rom[11] = mw(7'h10);
    mem.rom[12] = {3'b101, 11'h010};
    mem.rom[16] = {4'b1100, ~x, k3};
    mem.rom[17] = mw(7'h0F);
    mem.rom[18] = {6'b110000, 8'hFF};
    mem.rom[19] = mw(REG_CAUSE);
    mem.rom[20] = {3'b101, 11'h014};
    s = {1'b0, k1} + {1'b0, k2};
    dcy = ({1'b0, k1[3:0]} + k2[3:0]) > 5'hF;
    r = (k1 | (8'h01 << b1)) & ~(8'h01 << b2);
    to = (src == RS_WDT) ? 8'h08 : 8'h18;
    exp_q.delete();
    exp_q.push_back({8'd2, 8'h0C, k1});
    exp_q.push_back({8'd4, 8'h0D, s[7:0]});
    exp_q.push_back({8'd5, 8'h05, 8'h00});
    exp_q.push_back({8'd6, 8'h0C, k1 | (8'h01 << b1)});
    exp_q.push_back({8'd7, 8'h0C, r});
    exp_q.push_back({8'd9, 8'h0E, r});
    exp_q.push_back({8'd10, 8'h0E, r + 8'h01});
    if (r[b3]) exp_q.push_back({8'd12, 8'h10, r});
    exp_q.push_back({8'd16, 8'h0F, k3});
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    rst_por_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check("cause after reset", {16'h0, cause_exp}, {16'h0, cause_out});
    check("flags after reset", {16'h0, to}, {16'h0, status_out});
    repeat (100) @(posedge clk_sys);
    check("flags", {16'h0, to | {5'h0, r == 8'hFF, dcy, s[8]}}, {16'h0, status_out});
    check("reads", 24'(10 + int'(r[b3])), 24'(n_rd));
    check("port reads", 24'd1, 24'(n_pa));
    check("missing writes", 24'd0, 24'(exp_q.size()));
    check("cause written", 24'h0000FF, {16'h0, cause_out});
  endtask
  // =========================================================
  // sequence and watchdog
  initial begin
    void'($urandom(49));
    run(RS_POR, 8'h00);
    run(RS_WDT, 8'hFF);
    run(RS_BOR, 8'hFE);
    complete_run();
  end
  initial begin
    #75000;
    fails++;
    complete_run();
  end
endmodule // core_instruction_execute_test
`default_nettype wire
